// [verilog/nva_pkg.sv]
/*
  Constants, register map and state types of the nonvolatile access unit.
  Assumes a single 250 MHz system clock and AXI4-Lite register access.
*/
// What this block does
// RQ1: Software loads store address and data first.
// RQ2: Store starts only after 55h, AAh, launch.
// RQ3: Launch refused unless store permit set.
// RQ4: Hardware never clears the store permit.
// RQ5: Clearing permit never aborts a running store.
// RQ6: Completion clears launch bit, sets done flag.
// RQ7: Done flag stays until software clears it.
// RQ8: Software masks interrupts during the unlock.
// RQ9: Software sets address, program select, then read.
// RQ10: Second instruction slot is stolen for fetch.
// RQ11: Fetched word lands in data registers next.
// RQ12: Data registers hold until read or written.
// RQ13: Software places two NOPs after program read.
// RQ14: Launch with program selected reverts, does nothing.
// RQ15: Power-up clears the store permit.
// RQ16: Power-up timer blocks stores for 64 ms.
// RQ17: Software keeps permit clear outside updates.
// RQ18: Software may verify each stored byte.
// RQ19: Select 0 means data, 1 program, read-only.
// RQ20: Launch bits set by software, cleared by hardware.
// RQ21: Reset during a store sets aborted flag.
// RQ22: Unlock port stores nothing, reads zero.
// RQ23: Any unexpected write resets the unlock tracker.
// RQ24: Store duration comes from a parameterised counter.

package nva_pkg;

  // ----------------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------------
  localparam int          AXI_AW      = 8;
  localparam int          AXI_DW      = 32;
  localparam logic [7:0]  OFF_ADDR_LO = 8'h00;
  localparam logic [7:0]  OFF_ADDR_HI = 8'h04;
  localparam logic [7:0]  OFF_DATA_LO = 8'h08;
  localparam logic [7:0]  OFF_DATA_HI = 8'h0C;
  localparam logic [7:0]  OFF_CTRL    = 8'h10;
  localparam logic [7:0]  OFF_UNLOCK  = 8'h14;
  localparam logic [7:0]  OFF_STATUS  = 8'h18;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Control and status fields
  // ----------------------------------------------------------------------
  localparam int          CTL_RD      = 0;
  localparam int          CTL_WR      = 1;
  localparam int          CTL_PERMIT  = 2;
  localparam int          CTL_ABORT   = 3;
  localparam int          CTL_SEL     = 7;
  localparam int          STS_DONE    = 0;
  localparam int          STS_PUT     = 1;
  localparam int          ADDR_HI_W   = 4;
  localparam int          DATA_HI_W   = 6;
  localparam logic [7:0]  UNLOCK_1ST  = 8'h55;
  localparam logic [7:0]  UNLOCK_2ND  = 8'hAA;
  localparam logic [7:0]  RST_BYTE    = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam longint      CLK_PERIOD_NS = 4;
  localparam longint      PUT_TIME_MS   = 64;
  localparam longint      PUT_CYCLES    = (PUT_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int          PUT_CNT_W     = 24;
  localparam longint      STORE_TIME_NS = 4000;
  localparam longint      STORE_CYCLES  = STORE_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {UNL_IDLE, UNL_GOT1, UNL_ARMED} nva_unlock_t;
  typedef enum logic [1:0] {FET_IDLE, FET_WAIT1, FET_WAIT2, FET_CAPT} nva_fetch_t;

endpackage

// [verilog/nva_store_timer.sv]
/*
  Store cycle timer: counts the programming time of one data byte.
  Assumes start is a one-cycle pulse and abort is a level from the CPU reset.
*/
`timescale 1ns/1ps

module nva_store_timer #(
  parameter int unsigned CYCLES = 1000
) (
  // Clock and control
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  input  wire logic clk_en_in,
  // Timer
  input  wire logic start_in,
  input  wire logic abort_in,
  output logic      busy_out,
  output logic      done_out
);

  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] cnt_reg;

  assign busy_out = (cnt_reg != '0);

  // The count is the whole programming time; only abort_in or resetn_in cuts it short. [RQ24]
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || (clk_en_in && abort_in)) begin
      cnt_reg  <= '0;
      done_out <= 1'b0;
    end else if (clk_en_in) begin
      done_out <= (cnt_reg == W'(1));
      if (start_in && !busy_out) begin
        cnt_reg <= W'(CYCLES);
      end else if (busy_out) begin
        cnt_reg <= cnt_reg - W'(1);
      end
    end
  end

endmodule

// [verilog/nva_core.sv]
/*
  Nonvolatile access unit: data byte stores behind an unlock sequence and
  program word fetches that steal one CPU instruction slot.
  Assumes the CPU issues instr_cycle_in once per instruction cycle and that
  the program memory returns a word in the same clock as its read strobe.
*/
`timescale 1ns/1ps

module nva_core
  #(
  parameter longint      PUT_CYCLES   = nva_pkg::PUT_CYCLES,
  parameter int unsigned STORE_CYCLES = 32'(nva_pkg::STORE_CYCLES)
) (
  // Clock, reset, enable
  input  wire logic                         clk_sys_in,
  input  wire logic                         resetn_in,
  input  wire logic                         clk_en_in,
  input  wire logic                         cpu_reset_in,
  // AXI4-Lite write channels
  input  wire logic [nva_pkg::AXI_AW-1:0]   s_axi_awaddr_in,
  input  wire logic                         s_axi_awvalid_in,
  output logic                              s_axi_awready_out,
  input  wire logic [nva_pkg::AXI_DW-1:0]   s_axi_wdata_in,
  input  wire logic [3:0]                   s_axi_wstrb_in,
  input  wire logic                         s_axi_wvalid_in,
  output logic                              s_axi_wready_out,
  output logic [1:0]                        s_axi_bresp_out,
  output logic                              s_axi_bvalid_out,
  input  wire logic                         s_axi_bready_in,
  // AXI4-Lite read channels
  input  wire logic [nva_pkg::AXI_AW-1:0]   s_axi_araddr_in,
  input  wire logic                         s_axi_arvalid_in,
  output logic                              s_axi_arready_out,
  output logic [nva_pkg::AXI_DW-1:0]        s_axi_rdata_out,
  output logic [1:0]                        s_axi_rresp_out,
  output logic                              s_axi_rvalid_out,
  input  wire logic                         s_axi_rready_in,
  // CPU pipeline
  input  wire logic                         instr_cycle_in,
  output logic                              slot_squash_out,
  output logic                              store_done_out,
  // Program memory port
  output logic                              flash_rd_out,
  output logic [11:0]                       flash_addr_out,
  input  wire logic [13:0]                  flash_data_in
);

  import nva_pkg::*;

  // ------------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------------
  logic [7:0]           mem [0:255];
  logic                 aw_full_reg, w_full_reg, w_lane_reg, bvalid_reg, rvalid_reg, flash_rd_reg;
  logic [AXI_AW-1:0]    aw_addr_reg;
  logic [1:0]           bresp_reg, rresp_reg;
  logic [AXI_DW-1:0]    rdata_reg;
  logic [7:0]           w_byte_reg, st_addr_reg, st_data_reg;
  logic [7:0]           addr_lo_reg, data_lo_reg, data_lo_next;
  logic [ADDR_HI_W-1:0] addr_hi_reg;
  logic [DATA_HI_W-1:0] data_hi_reg, data_hi_next;
  logic                 sel_reg, permit_reg, abort_reg, wr_reg, rd_reg, done_flag_reg;
  logic [11:0]          flash_addr_reg;
  logic [PUT_CNT_W-1:0] put_cnt_reg;
  nva_unlock_t          unl_state_reg, unl_state_next;
  nva_fetch_t           fet_state_reg, fet_state_next;

  function automatic logic hit(input logic [AXI_AW-1:0] a, input logic [7:0] off);
    hit = (a[AXI_AW-1:2] == off[AXI_AW-1:2]);
  endfunction
  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    mapped = (a[AXI_AW-1:2] <= OFF_STATUS[AXI_AW-1:2]);
  endfunction

  // ------------------------------------------------------------------------
  // Bus slave decode
  // ------------------------------------------------------------------------
  wire       wr_fire   = clk_en_in && aw_full_reg && w_full_reg && !bvalid_reg;
  wire       ar_take   = clk_en_in && s_axi_arvalid_in && !rvalid_reg;
  wire       sw_wr     = wr_fire && w_lane_reg;
  wire [7:0] b         = w_byte_reg;
  wire       wr_adlo   = sw_wr && hit(aw_addr_reg, OFF_ADDR_LO);
  wire       wr_adhi   = sw_wr && hit(aw_addr_reg, OFF_ADDR_HI);
  wire       wr_dlo    = sw_wr && hit(aw_addr_reg, OFF_DATA_LO);
  wire       wr_dhi    = sw_wr && hit(aw_addr_reg, OFF_DATA_HI);
  wire       wr_ctl    = sw_wr && hit(aw_addr_reg, OFF_CTRL);
  wire       wr_unl    = sw_wr && hit(aw_addr_reg, OFF_UNLOCK);
  wire       wr_sts    = sw_wr && hit(aw_addr_reg, OFF_STATUS);
  wire       put_busy  = (put_cnt_reg != '0);
  wire       st_busy, st_done;

  assign s_axi_awready_out = clk_en_in && !aw_full_reg;
  assign s_axi_wready_out  = clk_en_in && !w_full_reg;
  assign s_axi_arready_out = clk_en_in && !rvalid_reg;
  assign s_axi_bvalid_out  = bvalid_reg;
  assign s_axi_bresp_out   = bresp_reg;
  assign s_axi_rvalid_out  = rvalid_reg;
  assign s_axi_rresp_out   = rresp_reg;
  assign s_axi_rdata_out   = rdata_reg;

  // The unlock port has no storage behind it and always reads zero. [RQ22]
  wire [7:0] ctl_byte = {sel_reg, 3'h0, abort_reg, permit_reg, wr_reg, rd_reg};
  wire [7:0] rd_byte  =
    hit(s_axi_araddr_in, OFF_ADDR_LO) ? addr_lo_reg :
    hit(s_axi_araddr_in, OFF_ADDR_HI) ? 8'(addr_hi_reg) :
    hit(s_axi_araddr_in, OFF_DATA_LO) ? data_lo_reg :
    hit(s_axi_araddr_in, OFF_DATA_HI) ? 8'(data_hi_reg) :
    hit(s_axi_araddr_in, OFF_CTRL)    ? ctl_byte :
    hit(s_axi_araddr_in, OFF_STATUS)  ? {6'h0, put_busy, done_flag_reg} :
    RST_BYTE;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_byte_reg  <= RST_BYTE;
      w_lane_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= '0;
    end else if (clk_en_in) begin
      if (s_axi_awvalid_in && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_full_reg) begin
        w_full_reg <= 1'b1;
        w_byte_reg <= s_axi_wdata_in[7:0];
        w_lane_reg <= s_axi_wstrb_in[0];
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready_in) begin
        bvalid_reg <= 1'b0;
      end
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
        rdata_reg  <= AXI_DW'(rd_byte);
      end else if (rvalid_reg && s_axi_rready_in) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------------
  // Unlock tracker and launch decisions
  // ------------------------------------------------------------------------
  // A store needs 55h, AAh and the launch in that order; any other write
  // in between drops the tracker back to idle, except a 55h, which restarts it. [RQ2] [RQ23]
  always_comb begin
    unl_state_next = unl_state_reg;
    if (wr_fire) begin
      if (wr_unl && b == UNLOCK_1ST) begin
        unl_state_next = UNL_GOT1;
      end else if (wr_unl && b == UNLOCK_2ND && unl_state_reg == UNL_GOT1) begin
        unl_state_next = UNL_ARMED;
      end else begin
        unl_state_next = UNL_IDLE;
      end
    end
  end

  // Launch needs the permit already set, data memory selected and the
  // power-up timer expired. [RQ3] [RQ14] [RQ16] [RQ19]
  wire launch_store = wr_ctl && b[CTL_WR] && unl_state_reg == UNL_ARMED && permit_reg &&
                      !b[CTL_SEL] && !put_busy && !wr_reg && !st_busy && !cpu_reset_in;
  wire launch_rd    = wr_ctl && b[CTL_RD] && !rd_reg && !cpu_reset_in;
  wire data_rd_now  = launch_rd && !b[CTL_SEL];
  wire fetch_cap    = (fet_state_reg == FET_CAPT);

  // ------------------------------------------------------------------------
  // Program word fetch
  // ------------------------------------------------------------------------
  // The first instruction after the launch runs; the second one is squashed
  // because its slot is spent on the program memory read. [RQ10]
  always_comb begin
    fet_state_next = fet_state_reg;
    case (fet_state_reg)
      FET_IDLE:  if (launch_rd && b[CTL_SEL]) fet_state_next = FET_WAIT1;
      FET_WAIT1: if (instr_cycle_in) fet_state_next = FET_WAIT2;
      FET_WAIT2: if (instr_cycle_in) fet_state_next = FET_CAPT;
      FET_CAPT:  fet_state_next = FET_IDLE;
      default:   fet_state_next = FET_IDLE;
    endcase
  end

  assign slot_squash_out = (fet_state_reg == FET_WAIT2) && instr_cycle_in;
  assign flash_rd_out    = flash_rd_reg;
  assign flash_addr_out  = flash_addr_reg;
  assign store_done_out  = done_flag_reg;

  // A captured word or a data read overrides a same-cycle software write;
  // otherwise the registers simply hold. [RQ11] [RQ12]
  assign data_lo_next = fetch_cap   ? flash_data_in[7:0] :
                        data_rd_now ? mem[addr_lo_reg] :
                        wr_dlo      ? b : data_lo_reg;
  assign data_hi_next = fetch_cap   ? flash_data_in[13:8] :
                        wr_dhi      ? b[DATA_HI_W-1:0] : data_hi_reg;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || (clk_en_in && cpu_reset_in)) begin
      fet_state_reg  <= FET_IDLE;
      flash_rd_reg   <= 1'b0;
      flash_addr_reg <= '0;
    end else if (clk_en_in) begin
      fet_state_reg <= fet_state_next;
      flash_rd_reg  <= slot_squash_out;
      if (slot_squash_out) begin
        flash_addr_reg <= {addr_hi_reg, addr_lo_reg};
      end
    end
  end

  // ------------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || (clk_en_in && cpu_reset_in)) begin
      addr_lo_reg   <= RST_BYTE;
      addr_hi_reg   <= '0;
      data_lo_reg   <= RST_BYTE;
      data_hi_reg   <= '0;
      sel_reg       <= 1'b0;
      permit_reg    <= 1'b0;              // [RQ15]
      wr_reg        <= 1'b0;
      rd_reg        <= 1'b0;
      unl_state_reg <= UNL_IDLE;
    end else if (clk_en_in) begin
      unl_state_reg <= unl_state_next;
      data_lo_reg   <= data_lo_next;
      data_hi_reg   <= data_hi_next;
      if (wr_adlo) addr_lo_reg <= b;
      if (wr_adhi) addr_hi_reg <= b[ADDR_HI_W-1:0];
      if (wr_ctl) begin
        sel_reg    <= b[CTL_SEL];
        permit_reg <= b[CTL_PERMIT];      // [RQ4]
      end
      // Launch bits are set only by software, cleared here or by reset. [RQ20]
      if (launch_store) begin
        wr_reg <= 1'b1;
      end else if (st_done) begin
        wr_reg <= 1'b0;                   // [RQ6]
      end
      if (launch_rd && b[CTL_SEL]) begin
        rd_reg <= 1'b1;
      end else if (fetch_cap) begin
        rd_reg <= 1'b0;
      end
    end
  end

  // The aborted flag survives the CPU reset so software can retry after it;
  // power-up or a control write with the abort bit clear clears it. [RQ21]
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      abort_reg     <= 1'b0;
      done_flag_reg <= 1'b0;
      put_cnt_reg   <= PUT_CNT_W'(PUT_CYCLES);   // [RQ16]
    end else if (clk_en_in) begin
      if (put_busy) put_cnt_reg <= put_cnt_reg - PUT_CNT_W'(1);
      if (cpu_reset_in && wr_reg) begin
        abort_reg <= 1'b1;
      end else if (wr_ctl && !cpu_reset_in) begin
        abort_reg <= b[CTL_ABORT];
      end
      // Set wins over a same-cycle clear. [RQ7]
      if (st_done) begin
        done_flag_reg <= 1'b1;
      end else if (wr_sts && b[STS_DONE]) begin
        done_flag_reg <= 1'b0;
      end
    end
  end

  // Address and data are latched at launch so later register writes, or
  // dropping the permit, cannot change the byte in flight. [RQ5]
  always_ff @(posedge clk_sys_in) begin
    if (clk_en_in) begin
      if (launch_store) begin
        st_addr_reg <= addr_lo_reg;
        st_data_reg <= data_lo_reg;
      end
      if (st_done) mem[st_addr_reg] <= st_data_reg;
    end
  end

  nva_store_timer #(
    .CYCLES (STORE_CYCLES)
  ) u_timer (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .clk_en_in  (clk_en_in),
    .start_in   (launch_store),
    .abort_in   (cpu_reset_in),
    .busy_out   (st_busy),
    .done_out   (st_done)
  );

  // ------------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------------
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  a_launch_needs_unlock: assert property ($rose(wr_reg) |-> $past(permit_reg) && // [RQ3]
    $past(unl_state_reg == UNL_ARMED)) else $error("store launched without unlock");
  a_permit_sw_only: assert property ($changed(permit_reg) |-> // [RQ4]
    $past(wr_ctl || (clk_en_in && cpu_reset_in))) else $error("permit changed by hardware");
  a_store_finish: assert property (clk_en_in && st_done && !cpu_reset_in |=> // [RQ6]
    !wr_reg && done_flag_reg) else $error("store completion not reflected");
  a_flag_sticky: assert property (done_flag_reg && !(wr_sts && b[STS_DONE]) |=> // [RQ7]
    done_flag_reg) else $error("done flag dropped by hardware");
  a_launch_holds: assert property (wr_reg && !st_done && !cpu_reset_in |=> // [RQ5]
    wr_reg) else $error("store launch bit cleared early");
  a_prog_no_store: assert property ($rose(wr_reg) |-> !sel_reg) // [RQ14]
    else $error("store launched with program memory selected");
  a_put_blocks: assert property (put_busy |=> !$rose(wr_reg)) // [RQ16]
    else $error("store launched during power-up timer");
  a_unlock_zero: assert property (ar_take && hit(s_axi_araddr_in, OFF_UNLOCK) |=> // [RQ22]
    s_axi_rvalid_out && s_axi_rdata_out == '0) else $error("unlock port read nonzero");
  a_steal_slot: assert property (clk_en_in && fet_state_reg == FET_WAIT2 && instr_cycle_in // [RQ10]
    && !cpu_reset_in |-> slot_squash_out ##1 flash_rd_out) else $error("slot not stolen");
  a_fetch_capture: assert property (clk_en_in && flash_rd_reg && !cpu_reset_in |=> // [RQ11]
    data_lo_reg == $past(flash_data_in[7:0]) && !rd_reg) else $error("fetch not captured");
  a_abort_mark: assert property (clk_en_in && cpu_reset_in && wr_reg |=> // [RQ21]
    abort_reg && !wr_reg) else $error("aborted store not flagged");

  c_store_done: cover property ($rose(done_flag_reg));
  c_fetch: cover property (fetch_cap);
  c_unlock_broken: cover property (unl_state_reg == UNL_GOT1 ##1 unl_state_reg == UNL_IDLE);
  c_abort: cover property ($rose(abort_reg));

endmodule

// [tb/data_eeprom_write_flash_read_bench.sv]
/*
  Self-checking bench of the nonvolatile access unit: AXI4-Lite master tasks,
  read and write result queues checked by a monitor, and CPU slot and program memory stimulus.
  Assumes the design's assertions live in its own files and a 250 MHz clock.
*/
`timescale 1ns/1ps

module data_eeprom_write_flash_read_bench;
  import nva_pkg::*;
  // ----------------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------------
  logic        clk_sys_in     = 1'b0;
  logic        resetn_in      = 1'b0;
  logic        cpu_reset_in   = 1'b0;
  logic        instr_cycle_in = 1'b0;
  logic [7:0]  awaddr         = 8'h00;
  logic [7:0]  araddr         = 8'h00;
  logic [31:0] wdata          = 32'h0000_0000;
  logic        awvalid        = 1'b0;
  logic        wvalid         = 1'b0;
  logic        arvalid        = 1'b0;
  logic [13:0] flash_data     = 14'h0000;
  logic        clk_en         = 1'b1;
  logic [3:0]  wstrb          = 4'hf;
  wire logic   awready, wready, bvalid, arready, rvalid, squash, done, frd;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [11:0] faddr;
  logic [33:0] rq[$];
  logic [33:0] bq[$];
  int          n_errors       = 0;
  int          total_checks   = 0;
  int          seed           = 32'h15070d26;
  logic [7:0]  a8, d8;
  logic [11:0] pa;
  logic [13:0] pw;

  always #2 clk_sys_in = ~clk_sys_in;

  nva_core #(.PUT_CYCLES(40), .STORE_CYCLES(30)) nva_core_i (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .clk_en_in(clk_en),
    .cpu_reset_in(cpu_reset_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(1'b1), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'b1),
    .instr_cycle_in(instr_cycle_in), .slot_squash_out(squash), .store_done_out(done),
    .flash_rd_out(frd), .flash_addr_out(faddr), .flash_data_in(flash_data));

  // ----------------------------------------------------------------------
  // Compare, bus tasks and closing report
  // ----------------------------------------------------------------------
  task automatic chk(input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    int i;
    @(posedge clk_sys_in);
    bq.push_back({32'h0000_0000, er});
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 40) begin
      n_errors++;
      wrap_up;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
    int i;
    @(posedge clk_sys_in);
    rq.push_back({er, 24'h00_0000, e});
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 40) begin
      n_errors++;
      wrap_up;
    end
  endtask

  // The unlock pair is always sent back to back, directly before the control write.
  task automatic unlock(input logic [7:0] ctl);
    wr(OFF_UNLOCK, UNLOCK_1ST);
    wr(OFF_UNLOCK, UNLOCK_2ND);
    wr(OFF_CTRL, ctl);
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Ready inputs are tied high, so every answer stands for exactly one cycle.
  always @(posedge clk_sys_in) begin
    if (rvalid) chk(rq.pop_front(), {rresp, rdata});
    if (bvalid) chk(bq.pop_front(), {32'h0000_0000, bresp});
  end

  initial begin
    #200000;
    n_errors++;
    wrap_up;
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    a8 = $random(seed);
    d8 = $random(seed);
    pa = $random(seed);
    pw = $random(seed);
    repeat (2) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    rd(OFF_CTRL, 8'h00);
    wr(OFF_CTRL, 8'h04);
    rd(OFF_STATUS, 8'h02);
    unlock(8'h06);
    rd(OFF_CTRL, 8'h04);
    clk_en <= 1'b0;
    repeat (30) @(posedge clk_sys_in);
    clk_en <= 1'b1;
    rd(OFF_STATUS, 8'h02);
    repeat (40) @(posedge clk_sys_in);
    rd(OFF_STATUS, 8'h00);
    rd(OFF_UNLOCK, 8'h00);
    rd(8'h1C, 8'h00, RESP_SLVERR);
    wr(8'h1C, 8'h5A, RESP_SLVERR);
    wr(OFF_CTRL, 8'h00);
    unlock(8'h02);
    rd(OFF_CTRL, 8'h00);
    wr(OFF_CTRL, 8'h04);
    wr(OFF_UNLOCK, UNLOCK_1ST);
    wr(OFF_ADDR_LO, a8);
    wr(OFF_UNLOCK, UNLOCK_2ND);
    wr(OFF_CTRL, 8'h06);
    rd(OFF_CTRL, 8'h04);
    wr(OFF_DATA_LO, d8);
    unlock(8'h06);
    rd(OFF_CTRL, 8'h06);
    wr(OFF_CTRL, 8'h00);
    rd(OFF_CTRL, 8'h02);
    for (int i = 0; i < 100 && done !== 1'b1; i++) @(posedge clk_sys_in);
    chk(34'(done), 34'h1);
    rd(OFF_CTRL, 8'h00);
    repeat (10) @(posedge clk_sys_in);
    rd(OFF_STATUS, 8'h01);
    wr(OFF_STATUS, 8'h01);
    rd(OFF_STATUS, 8'h00);
    wr(OFF_DATA_LO, ~d8);
    wr(OFF_CTRL, 8'h01);
    rd(OFF_DATA_LO, d8);
    wr(OFF_CTRL, 8'h04);
    unlock(8'h86);
    rd(OFF_CTRL, 8'h84);
    repeat (40) @(posedge clk_sys_in);
    rd(OFF_STATUS, 8'h00);
    wr(OFF_ADDR_LO, pa[7:0]);
    wr(OFF_ADDR_HI, {4'h0, pa[11:8]});
    flash_data <= pw;
    wr(OFF_CTRL, 8'h81);
    @(posedge clk_sys_in);
    instr_cycle_in <= 1'b1;
    #1 chk(34'(squash), 34'h0);
    @(posedge clk_sys_in);
    instr_cycle_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    instr_cycle_in <= 1'b1;
    #1 chk(34'(squash), 34'h1);
    @(posedge clk_sys_in);
    instr_cycle_in <= 1'b0;
    #1 chk({21'h00_0000, frd, faddr}, {21'h00_0001, pa});
    @(posedge clk_sys_in);
    flash_data <= ~pw;
    rd(OFF_DATA_LO, pw[7:0]);
    rd(OFF_DATA_HI, {2'h0, pw[13:8]});
    rd(OFF_CTRL, 8'h80);
    rd(OFF_DATA_LO, pw[7:0]);
    wstrb <= 4'h0;
    wr(OFF_DATA_LO, ~pw[7:0]);
    wstrb <= 4'hf;
    rd(OFF_DATA_LO, pw[7:0]);
    wr(OFF_CTRL, 8'h04);
    unlock(8'h06);
    @(posedge clk_sys_in);
    cpu_reset_in <= 1'b1;
    @(posedge clk_sys_in);
    cpu_reset_in <= 1'b0;
    rd(OFF_CTRL, 8'h08);
    repeat (40) @(posedge clk_sys_in);
    rd(OFF_STATUS, 8'h00);
    wr(OFF_CTRL, 8'h00);
    rd(OFF_CTRL, 8'h00);
    wrap_up;
  end
endmodule
